// [verilog/qtl_trigger.sv]
// Qualified, video, dropout and width trigger logic
`default_nettype none
`include "qtl_consts.svh"
// How it works
// - State mode: pattern must hold until trigger
// - Edge mode: validation alone suffices afterwards
// - Each validation restarts delay or event count
// - Pattern is AND of per-source states
// - Only trigger source edge fires; source excluded
// - Delay 10 ns to 20 s, events to 99999999
// - State time wait: start at onset, fire after
// - State event wait: count while pattern, fire
// - Wait armed at onset, disabled when absent
// - Edge time wait: expire before pattern ends
// - Edge event wait: count until pattern ends
// - Video: field start, count lines, fire line
// - 625 setting: lines 1 to 626, 626 is 1
// - 525 setting: lines 1 to 1051, 1051 is 1
// - Custom video counts every sync pulse
// - Field numbers relative to arbitrary start
// - Sync pulses decoded as negative going
// - Dropout restarts on edge, fires on timeout
// - Upper test fires on pulse narrower than limit
// - Lower test fires on pulse wider than limit
// - Both tests: range AND, otherwise OR
// - Width pattern variant ANDs up to five sources
// - Field sequence of up to eight fields
module qtl_trigger #(
    parameter int NSRC = 5,
    parameter logic [31:0] TIME_MAX_CYC = 32'(`QTL_TIME_MAX_CYC),
    parameter logic [31:0] EVT_MAX = 32'(`QTL_EVT_MAX)
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire qtl_pkg::qtl_bus_t bus_i,
    output logic [31:0] rdata_o,
    input wire logic [NSRC-1:0] cmp_i,
    output logic trig_o
);
    // ****************************************
    // Registers
    // ****************************************
    qtl_pkg::qtl_ctrl_t ctrl_r;
    logic [NSRC-1:0] care_r, val_r;
    logic [31:0] wait_r, upper_r, lower_r, drop_r;
    logic [10:0] vline_r;
    logic [3:0] nfld_r;
    logic [2:0] fnum_r;
    logic [15:0] tcnt_r;
    qtl_pkg::qtl_qstate_t q_st_r;
    logic [31:0] q_cnt_r;
    logic qual_q_r;
    logic [2:0] v_fld_r;

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            ctrl_r <= qtl_pkg::qtl_ctrl_t'(`QTL_CTRL_RST);
            care_r <= '0;
            val_r <= '0;
            wait_r <= `QTL_TIME_RST;
            upper_r <= `QTL_TIME_RST;
            lower_r <= `QTL_TIME_RST;
            drop_r <= `QTL_TIME_RST;
            vline_r <= `QTL_LINE_RST;
            nfld_r <= `QTL_NFLD_RST;
            fnum_r <= '0;
        end else if (bus_i.wr) begin
            case (bus_i.addr)
                `QTL_REG_CTRL: ctrl_r <= qtl_pkg::qtl_ctrl_t'(bus_i.wdata);
                `QTL_REG_PAT: begin
                    care_r <= bus_i.wdata[NSRC-1:0];
                    val_r <= bus_i.wdata[`QTL_PAT_VAL_LSB +: NSRC];
                end
                `QTL_REG_WAIT: wait_r <= bus_i.wdata;
                `QTL_REG_UPPER: upper_r <= bus_i.wdata;
                `QTL_REG_LOWER: lower_r <= bus_i.wdata;
                `QTL_REG_DROP: drop_r <= bus_i.wdata;
                `QTL_REG_VIDEO: begin
                    vline_r <= bus_i.wdata[`QTL_VID_LINE_LSB +: 11];
                    nfld_r <= bus_i.wdata[`QTL_VID_NFLD_LSB +: 4];
                    fnum_r <= bus_i.wdata[`QTL_VID_FNUM_LSB +: 3];
                end
                default: ;
            endcase
        end
    end

    // Read data, one cycle after the strobe
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            rdata_o <= '0;
        end else if (bus_i.rd) begin
            case (bus_i.addr)
                `QTL_REG_CTRL: rdata_o <= 32'(ctrl_r);
                `QTL_REG_PAT: rdata_o <= 32'(care_r) | (32'(val_r) << `QTL_PAT_VAL_LSB);
                `QTL_REG_WAIT: rdata_o <= wait_r;
                `QTL_REG_UPPER: rdata_o <= upper_r;
                `QTL_REG_LOWER: rdata_o <= lower_r;
                `QTL_REG_DROP: rdata_o <= drop_r;
                `QTL_REG_VIDEO: rdata_o <= (32'(vline_r) << `QTL_VID_LINE_LSB)
                    | (32'(nfld_r) << `QTL_VID_NFLD_LSB) | (32'(fnum_r) << `QTL_VID_FNUM_LSB);
                `QTL_REG_STATUS: rdata_o <= 32'(tcnt_r) | (32'(qual_q_r) << `QTL_ST_QUAL_BIT)
                    | (32'(q_st_r) << `QTL_ST_QST_LSB) | (32'(v_fld_r) << `QTL_ST_FLD_LSB);
                default: rdata_o <= '0;
            endcase
        end else begin
            rdata_o <= '0;
        end
    end

    // ****************************************
    // Limits
    // ****************************************
    function automatic logic [31:0] clamp(input logic [31:0] v, input logic [31:0] lo,
                                          input logic [31:0] hi);
        clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction

    logic [31:0] wait_eff, evt_eff, up_eff, lo_eff, drop_eff;
    assign wait_eff = clamp(wait_r, 32'(`QTL_WAIT_MIN_CYC), TIME_MAX_CYC);
    assign evt_eff = clamp(wait_r, 32'h0000_0001, EVT_MAX);
    assign up_eff = clamp(upper_r, 32'(`QTL_WIDTH_MIN_CYC), TIME_MAX_CYC);
    assign lo_eff = clamp(lower_r, 32'(`QTL_WIDTH_MIN_CYC), TIME_MAX_CYC);
    assign drop_eff = clamp(drop_r, 32'(`QTL_DROP_MIN_CYC), TIME_MAX_CYC);

    // ****************************************
    // Source edges and pattern
    // ****************************************
    logic [NSRC-1:0] cmp_q_r, term;
    logic src_now, src_prev, trig_edge, pat, pat_q_r, qual, onset, is_q;
    assign is_q = (ctrl_r.mode == qtl_pkg::QTL_M_STATE) || (ctrl_r.mode == qtl_pkg::QTL_M_EDGE);
    assign src_now = cmp_i[ctrl_r.src];
    assign src_prev = cmp_q_r[ctrl_r.src];
    assign trig_edge = ctrl_r.slope_neg ? (src_prev & ~src_now) : (~src_prev & src_now);

    for (genvar i = 0; i < NSRC; i++) begin : g_term
        // Source in its wanted state, or ignored
        assign term[i] = ~care_r[i] | (cmp_i[i] == val_r[i])
            | (is_q && (ctrl_r.src == 3'(i)));
    end
    assign pat = &term;
    assign qual = ctrl_r.pat_present ? pat : ~pat;
    assign onset = is_q & qual & ~qual_q_r;

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            cmp_q_r <= '0;
            pat_q_r <= 1'b0;
            qual_q_r <= 1'b0;
        end else begin
            cmp_q_r <= cmp_i;
            pat_q_r <= pat;
            qual_q_r <= qual;
        end
    end

    // ****************************************
    // Qualified triggers
    // ****************************************
    logic q_fire, q_drop, evt_hit;
    assign q_drop = ~qual && (q_st_r == qtl_pkg::QTL_Q_RUN
        || ctrl_r.mode == qtl_pkg::QTL_M_STATE);
    assign evt_hit = trig_edge && (q_cnt_r + 32'h0000_0001 >= evt_eff);
    assign q_fire = is_q && trig_edge && !onset && !q_drop
        && ((q_st_r == qtl_pkg::QTL_Q_READY)
        || (q_st_r == qtl_pkg::QTL_Q_RUN && ctrl_r.wait_evt && evt_hit));

    always_ff @(posedge core_clk_i) begin
        if (rst_i || !is_q) begin
            q_st_r <= qtl_pkg::QTL_Q_IDLE;
            q_cnt_r <= '0;
        end else if (onset) begin
            q_st_r <= qtl_pkg::QTL_Q_RUN;
            q_cnt_r <= '0;
        end else if (q_drop) begin
            q_st_r <= qtl_pkg::QTL_Q_IDLE;
        end else begin
            case (q_st_r)
                qtl_pkg::QTL_Q_RUN: begin
                    if (ctrl_r.wait_evt) begin
                        if (evt_hit) begin
                            q_st_r <= qtl_pkg::QTL_Q_IDLE;
                        end else if (trig_edge) begin
                            q_cnt_r <= q_cnt_r + 32'h0000_0001;
                        end
                    end else if (q_cnt_r + 32'h0000_0001 >= wait_eff) begin
                        q_st_r <= qtl_pkg::QTL_Q_READY;
                    end else begin
                        q_cnt_r <= q_cnt_r + 32'h0000_0001;
                    end
                end
                qtl_pkg::QTL_Q_READY: q_st_r <= qtl_pkg::QTL_Q_READY;
                default: q_st_r <= qtl_pkg::QTL_Q_IDLE;
            endcase
        end
    end

    // ****************************************
    // Dropout
    // ****************************************
    logic [31:0] d_cnt_r;
    logic d_arm_r, d_fire;
    assign d_fire = (ctrl_r.mode == qtl_pkg::QTL_M_DROP) && d_arm_r && !trig_edge
        && (d_cnt_r + 32'h0000_0001 >= drop_eff);

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            d_cnt_r <= '0;
            d_arm_r <= 1'b0;
        end else if (trig_edge) begin
            d_cnt_r <= '0;
            d_arm_r <= 1'b1;
        end else if (d_fire) begin
            d_arm_r <= 1'b0;
        end else if (d_arm_r) begin
            d_cnt_r <= d_cnt_r + 32'h0000_0001;
        end
    end

    // ****************************************
    // Pulse width
    // ****************************************
    logic [31:0] g_w_r;
    logic g_val_r, g_lvl, g_lvl_prev, g_end, up_ok, lo_ok, g_pass, g_fire;
    assign g_lvl = ctrl_r.gl_pos ~^ (ctrl_r.gl_pat ? pat : src_now);
    assign g_lvl_prev = ctrl_r.gl_pos ~^ (ctrl_r.gl_pat ? pat_q_r : src_prev);
    assign g_end = g_val_r && g_lvl_prev && !g_lvl;
    assign up_ok = g_w_r < up_eff;
    assign lo_ok = g_w_r > lo_eff;
    always_comb begin
        if (ctrl_r.up_en && ctrl_r.lo_en) begin
            g_pass = (up_eff > lo_eff) ? (up_ok & lo_ok) : (up_ok | lo_ok);
        end else begin
            g_pass = (ctrl_r.up_en & up_ok) | (ctrl_r.lo_en & lo_ok);
        end
    end
    assign g_fire = (ctrl_r.mode == qtl_pkg::QTL_M_GLITCH) && g_end && g_pass;

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            g_w_r <= '0;
            g_val_r <= 1'b0;
        end else if (g_lvl && !g_lvl_prev) begin
            g_w_r <= 32'h0000_0001;
            g_val_r <= 1'b1;
        end else if (g_lvl && g_w_r < TIME_MAX_CYC) begin
            g_w_r <= g_w_r + 32'h0000_0001;
        end
    end

    // ****************************************
    // Video
    // ****************************************
    logic [15:0] v_w_r, v_gap_r;
    logic [10:0] v_line_r, v_max, v_tgt;
    logic [3:0] v_nf;
    logic [2:0] v_fnext;
    logic v_broad_r, v_run_r, sync, sync_prev, v_ls, v_fs, v_match, v_fire;
    assign sync = ~src_now;
    assign sync_prev = ~src_prev;
    assign v_ls = sync && !sync_prev
        && (ctrl_r.vid_custom || v_gap_r >= 16'(`QTL_LINE_MIN_CYC));
    assign v_fs = !sync && sync_prev && !v_broad_r && v_w_r >= 16'(`QTL_VSYNC_MIN_CYC);
    assign v_nf = (nfld_r == 4'h0 || nfld_r > `QTL_FIELDS_MAX) ? 4'h1 : nfld_r;
    assign v_fnext = (4'(v_fld_r) + 4'h1 >= v_nf) ? 3'h0 : v_fld_r + 3'h1;
    always_comb begin
        case (ctrl_r.fsel)
            qtl_pkg::QTL_F_ODD: v_match = !v_fnext[0];
            qtl_pkg::QTL_F_EVEN: v_match = v_fnext[0];
            qtl_pkg::QTL_F_NUM: v_match = (v_fnext == fnum_r);
            default: v_match = 1'b1;
        endcase
    end
    assign v_max = ctrl_r.vid_525 ? `QTL_LINES_525 : `QTL_LINES_625;
    assign v_tgt = (vline_r == 11'h000 || (!ctrl_r.vid_custom && vline_r >= v_max))
        ? 11'h001 : vline_r;
    assign v_fire = (ctrl_r.mode == qtl_pkg::QTL_M_VIDEO) && v_run_r && v_ls
        && (v_line_r + 11'h001 == v_tgt);

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            v_w_r <= '0;
            v_gap_r <= '0;
            v_broad_r <= 1'b0;
            v_fld_r <= '0;
        end else begin
            v_w_r <= sync ? ((v_w_r == 16'hffff) ? v_w_r : v_w_r + 16'h0001) : 16'h0000;
            if (v_ls) begin
                v_gap_r <= '0;
            end else if (v_gap_r != 16'hffff) begin
                v_gap_r <= v_gap_r + 16'h0001;
            end
            if (!sync && sync_prev) begin
                v_broad_r <= v_w_r >= 16'(`QTL_VSYNC_MIN_CYC);
            end
            if (v_fs) begin
                v_fld_r <= v_fnext;
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            v_line_r <= '0;
            v_run_r <= 1'b0;
        end else if (v_fs && v_match) begin
            v_line_r <= '0;
            v_run_r <= 1'b1;
        end else if (v_fire) begin
            v_run_r <= 1'b0;
        end else if (v_ls && v_run_r) begin
            v_line_r <= v_line_r + 11'h001;
        end
    end

    // ****************************************
    // Trigger output
    // ****************************************
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            trig_o <= 1'b0;
            tcnt_r <= '0;
        end else begin
            trig_o <= q_fire | d_fire | g_fire | v_fire;
            if (q_fire | d_fire | g_fire | v_fire) begin
                tcnt_r <= tcnt_r + 16'h0001;
            end
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (rst_i);

    sequence s_onset;
        onset ##1 (q_st_r == qtl_pkg::QTL_Q_RUN);
    endsequence
    property p_restart;
        onset |-> s_onset ##0 (q_cnt_r == 32'h0000_0000);
    endproperty
    a_restart: assert property (p_restart) else $error("onset did not restart");
    property p_state_drop;
        (ctrl_r.mode == qtl_pkg::QTL_M_STATE) && !qual |=> q_st_r == qtl_pkg::QTL_Q_IDLE;
    endproperty
    a_state_drop: assert property (p_state_drop) else $error("wait not disabled");
    property p_edge_hold;
        (ctrl_r.mode == qtl_pkg::QTL_M_EDGE) && $stable(ctrl_r) && !onset
            && q_st_r == qtl_pkg::QTL_Q_READY |=> q_st_r == qtl_pkg::QTL_Q_READY;
    endproperty
    a_edge_hold: assert property (p_edge_hold) else $error("edge ready lost");
    property p_src_only;
        is_q && !trig_edge |=> !trig_o;
    endproperty
    a_src_only: assert property (p_src_only) else $error("fire without edge");
    property p_ready_time;
        q_st_r == qtl_pkg::QTL_Q_READY && $stable(ctrl_r)
            |-> q_cnt_r + 32'h0000_0001 >= wait_eff;
    endproperty
    a_ready_time: assert property (p_ready_time) else $error("ready too early");
    property p_drop_restart;
        (ctrl_r.mode == qtl_pkg::QTL_M_DROP) && trig_edge
            |=> d_arm_r && d_cnt_r == 32'h0000_0000 ##1 !trig_o;
    endproperty
    a_drop_restart: assert property (p_drop_restart) else $error("dropout not restarted");
    property p_glitch_end;
        $past(ctrl_r.mode == qtl_pkg::QTL_M_GLITCH) && trig_o |-> $past(g_end && g_pass);
    endproperty
    a_glitch_end: assert property (p_glitch_end) else $error("width fire off pulse end");
    property p_video_line;
        $past(ctrl_r.mode == qtl_pkg::QTL_M_VIDEO) && trig_o |-> $past(v_ls && v_run_r);
    endproperty
    a_video_line: assert property (p_video_line) else $error("video fire off line");
endmodule // qtl_trigger
`default_nettype wire

// [verilog/qtl_consts.svh]
// Register map, field positions, reset values and timing counts
`ifndef QTL_CONSTS_SVH
`define QTL_CONSTS_SVH
// Register word indexes
`define QTL_REG_CTRL 4'h0
`define QTL_REG_PAT 4'h1
`define QTL_REG_WAIT 4'h2
`define QTL_REG_UPPER 4'h3
`define QTL_REG_LOWER 4'h4
`define QTL_REG_DROP 4'h5
`define QTL_REG_VIDEO 4'h6
`define QTL_REG_STATUS 4'h7
// Field positions
`define QTL_PAT_VAL_LSB 8
`define QTL_VID_LINE_LSB 0
`define QTL_VID_NFLD_LSB 16
`define QTL_VID_FNUM_LSB 24
`define QTL_ST_QUAL_BIT 16
`define QTL_ST_QST_LSB 17
`define QTL_ST_FLD_LSB 20
// Reset values
`define QTL_CTRL_RST 32'h0000_0000
`define QTL_PAT_RST 32'h0000_0000
`define QTL_TIME_RST 32'h0000_0001
`define QTL_LINE_RST 11'h001
`define QTL_NFLD_RST 4'h1
// Timing, clock period 10 ns
`define QTL_CLK_PS 10000
`define QTL_WAIT_MIN_PS 10000
`define QTL_WAIT_MIN_CYC ((`QTL_WAIT_MIN_PS + `QTL_CLK_PS - 1) / `QTL_CLK_PS)
`define QTL_DROP_MIN_PS 25000
`define QTL_DROP_MIN_CYC ((`QTL_DROP_MIN_PS + `QTL_CLK_PS - 1) / `QTL_CLK_PS)
`define QTL_WIDTH_MIN_PS 2500
`define QTL_WIDTH_MIN_CYC ((`QTL_WIDTH_MIN_PS + `QTL_CLK_PS - 1) / `QTL_CLK_PS)
`define QTL_TIME_MAX_S 20
`define QTL_TIME_MAX_CYC (64'd1_000_000_000_000 * `QTL_TIME_MAX_S / `QTL_CLK_PS)
`define QTL_EVT_MAX 99_999_999
`define QTL_VSYNC_MIN_PS 10_000_000
`define QTL_VSYNC_MIN_CYC ((`QTL_VSYNC_MIN_PS + `QTL_CLK_PS - 1) / `QTL_CLK_PS)
`define QTL_LINE_MIN_PS 40_000_000
`define QTL_LINE_MIN_CYC ((`QTL_LINE_MIN_PS + `QTL_CLK_PS - 1) / `QTL_CLK_PS)
`define QTL_LINES_625 11'd626
`define QTL_LINES_525 11'd1051
`define QTL_FIELDS_MAX 4'h8
`endif

// [verilog/qtl_pkg.sv]
// Types of the trigger qualifier
`default_nettype none
package qtl_pkg;
    typedef enum logic [2:0] {
        QTL_M_STATE = 3'h0,
        QTL_M_EDGE = 3'h1,
        QTL_M_VIDEO = 3'h2,
        QTL_M_DROP = 3'h3,
        QTL_M_GLITCH = 3'h4
    } qtl_mode_t;
    typedef enum logic [1:0] {
        QTL_F_ANY = 2'h0,
        QTL_F_ODD = 2'h1,
        QTL_F_EVEN = 2'h2,
        QTL_F_NUM = 2'h3
    } qtl_fsel_t;
    typedef enum logic [2:0] {
        QTL_Q_IDLE = 3'b001,
        QTL_Q_RUN = 3'b010,
        QTL_Q_READY = 3'b100
    } qtl_qstate_t;
    typedef struct packed {
        logic [14:0] rsvd;
        qtl_fsel_t fsel;
        logic vid_custom;
        logic vid_525;
        logic gl_pat;
        logic lo_en;
        logic up_en;
        logic gl_pos;
        logic pat_present;
        logic slope_neg;
        logic [2:0] src;
        logic wait_evt;
        qtl_mode_t mode;
    } qtl_ctrl_t;
    typedef struct packed {
        logic [3:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } qtl_bus_t;
endpackage
`default_nettype wire

// [dv/qtl_front_end_model.sv]
// Comparator front end model that feeds the trigger qualifier
`default_nettype none
module qtl_front_end_model #(
    parameter int NSRC = 5
) (
    input wire logic core_clk_i,
    input wire logic [NSRC-1:0] level_above_i,
    output var logic [NSRC-1:0] cmp_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************
    // Sampled comparator states
    // ****************************************
    // One bit a source, high while above its level, sampled on the timebase
    initial cmp_o = '0;
    always @(posedge core_clk_i) begin
        cmp_o <= level_above_i;
    end
endmodule // qtl_front_end_model
`default_nettype wire

// [dv/test_qualified_trigger_logic.sv]
// Self-checking bench for the qualified trigger logic
`default_nettype none
`include "qtl_consts.svh"
module test_qualified_trigger_logic;
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************
    // Types and signals
    // ****************************************
    typedef struct {
        logic [15:0] ctrl;
        logic [15:0] pat;
        int v;
        int up;
        int lo;
        int gap;
        int drop;
        int n;
        int wid;
        int exp;
    } qtl_row_t;
    logic core_clk;
    logic rst;
    qtl_pkg::qtl_bus_t bus;
    logic [31:0] rdata;
    logic [4:0] lvl;
    logic [4:0] cmp;
    logic trig;
    int errors;
    int total_checks;
    int trig_cnt;
    int base;
    logic [31:0] v;
    qtl_row_t rows[$];
    // ****************************************
    // Design and front end
    // ****************************************
    qtl_trigger #(
        .NSRC(5),
        .TIME_MAX_CYC(32'h0000_03E8),
        .EVT_MAX(32'h0000_0064)
    ) dut_u (
        .core_clk_i(core_clk),
        .rst_i(rst),
        .bus_i(bus),
        .rdata_o(rdata),
        .cmp_i(cmp),
        .trig_o(trig)
    );
    qtl_front_end_model #(
        .NSRC(5)
    ) fe_u (
        .core_clk_i(core_clk),
        .level_above_i(lvl),
        .cmp_o(cmp)
    );
    always #5 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        if (trig === 1'b1) begin
            trig_cnt <= trig_cnt + 1;
        end
    end
    // ****************************************
    // Tasks
    // ****************************************
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        bus.addr <= a;
        bus.wdata <= d;
        bus.wr <= 1'b1;
        @(posedge core_clk);
        bus.wr <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        bus.addr <= a;
        bus.rd <= 1'b1;
        @(posedge core_clk);
        bus.rd <= 1'b0;
        #1;
        d = rdata;
        @(posedge core_clk);
    endtask
    task automatic chk_resets();
        logic [31:0] d;
        logic [31:0] tab [7];
        tab = '{`QTL_CTRL_RST, `QTL_PAT_RST, `QTL_TIME_RST, `QTL_TIME_RST, `QTL_TIME_RST,
            `QTL_TIME_RST, (32'(`QTL_NFLD_RST) << `QTL_VID_NFLD_LSB) | 32'(`QTL_LINE_RST)};
        for (int i = 0; i < 7; i++) begin
            rd(4'(i), d);
            chk("register reset value", d, tab[i]);
        end
        rd(`QTL_REG_STATUS, d);
        chk("trigger count after reset", {16'h0000, d[15:0]}, 32'h0000_0000);
    endtask
    task automatic stop_test();
        $display("Checks: %0d, errors: %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // ****************************************
    // Watchdog
    // ****************************************
    initial begin
        repeat (20000) @(posedge core_clk);
        errors++;
        stop_test();
    end
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        core_clk = 1'b0;
        rst = 1'b1;
        bus = '0;
        lvl = 5'h00;
        errors = 0;
        total_checks = 0;
        trig_cnt = 0;
        // ctrl, pat, wait/drop, upper, lower, gap, drop, pulses, width, triggers
        rows = '{
            '{16'h0100, 16'h0202, 3, 1, 1, 8, 0, 1, 1, 1},
            '{16'h0100, 16'h0202, 3, 1, 1, 1, 0, 1, 1, 0},
            '{16'h0100, 16'h0202, 3, 1, 1, 8, 6, 1, 1, 0},
            '{16'h0100, 16'h0202, 3, 1, 1, 8, 0, 0, 1, 0},
            '{16'h0100, 16'h0606, 3, 1, 1, 8, 0, 1, 1, 0},
            '{16'h0101, 16'h0202, 3, 1, 1, 8, 6, 1, 1, 1},
            '{16'h0101, 16'h0202, 3, 1, 1, 1, 0, 1, 1, 0},
            '{16'h0101, 16'h0202, 3, 1, 1, 2, 1, 1, 1, 0},
            '{16'h0108, 16'h0202, 3, 1, 1, 2, 0, 3, 1, 1},
            '{16'h0108, 16'h0202, 3, 1, 1, 2, 0, 2, 1, 0},
            '{16'h0108, 16'h0202, 3, 1, 1, 2, 0, 4, 1, 1},
            '{16'h0108, 16'h0202, 3, 1, 1, 2, 1, 3, 1, 0},
            '{16'h0109, 16'h0202, 3, 1, 1, 2, 0, 3, 1, 1},
            '{16'h0109, 16'h0202, 3, 1, 1, 2, 1, 3, 1, 0},
            '{16'h0103, 16'h0000, 5, 1, 1, 2, 0, 1, 1, 1},
            '{16'h0103, 16'h0000, 5, 1, 1, 2, 0, 3, 1, 1},
            '{16'h0103, 16'h0000, 5, 1, 1, 2, 0, 0, 1, 0},
            '{16'h0604, 16'h0000, 1, 4, 1, 2, 0, 1, 2, 1},
            '{16'h0604, 16'h0000, 1, 4, 1, 2, 0, 1, 6, 0},
            '{16'h0A04, 16'h0000, 1, 1, 4, 2, 0, 1, 6, 1},
            '{16'h0A04, 16'h0000, 1, 1, 4, 2, 0, 1, 2, 0},
            '{16'h0E04, 16'h0000, 1, 8, 3, 2, 0, 1, 5, 1},
            '{16'h0E04, 16'h0000, 1, 8, 3, 2, 0, 1, 10, 0},
            '{16'h0E04, 16'h0000, 1, 3, 8, 2, 0, 1, 10, 1},
            '{16'h0E04, 16'h0000, 1, 3, 8, 2, 0, 1, 5, 0},
            '{16'h1604, 16'h0303, 1, 4, 1, 8, 0, 1, 2, 1},
            '{16'h1604, 16'h0707, 1, 4, 1, 8, 0, 1, 2, 0}
        };
        repeat (10) @(posedge core_clk);
        rst <= 1'b0;
        chk_resets();
        wr(`QTL_REG_CTRL, 32'hFFFE_0000);
        rd(`QTL_REG_CTRL, v);
        chk("reserved control bits", v, 32'hFFFE_0000);
        rd(4'h8, v);
        chk("unmapped read", v, 32'h0000_0000);
        foreach (rows[i]) begin
            wr(`QTL_REG_CTRL, {16'h0000, rows[i].ctrl});
            wr(`QTL_REG_PAT, {16'h0000, rows[i].pat});
            wr(`QTL_REG_WAIT, 32'(rows[i].v));
            wr(`QTL_REG_DROP, 32'(rows[i].v));
            wr(`QTL_REG_UPPER, 32'(rows[i].up));
            wr(`QTL_REG_LOWER, 32'(rows[i].lo));
            repeat (4) @(posedge core_clk);
            base = trig_cnt;
            lvl[1] <= 1'b1;
            for (int c = 1; c <= rows[i].gap; c++) begin
                @(posedge core_clk);
                if (c == rows[i].drop) begin
                    lvl[1] <= 1'b0;
                end
            end
            repeat (rows[i].n) begin
                lvl[0] <= 1'b1;
                repeat (rows[i].wid) @(posedge core_clk);
                lvl[0] <= 1'b0;
                repeat (2) @(posedge core_clk);
            end
            repeat (20) @(posedge core_clk);
            chk("trigger count", 32'(trig_cnt - base), 32'(rows[i].exp));
            lvl <= 5'h00;
        end
        // Custom video: short pulse, long field pulse, then counted lines
        lvl <= 5'h01;
        repeat (4) @(posedge core_clk);
        lvl[0] <= 1'b0;
        repeat (3) @(posedge core_clk);
        lvl[0] <= 1'b1;
        repeat (4) @(posedge core_clk);
        wr(`QTL_REG_CTRL, 32'h0000_4002);
        wr(`QTL_REG_VIDEO, 32'h0001_0002);
        lvl[0] <= 1'b0;
        repeat (1100) @(posedge core_clk);
        lvl[0] <= 1'b1;
        repeat (6) @(posedge core_clk);
        base = trig_cnt;
        repeat (3) begin
            lvl[0] <= 1'b0;
            repeat (3) @(posedge core_clk);
            lvl[0] <= 1'b1;
            repeat (5) @(posedge core_clk);
        end
        repeat (10) @(posedge core_clk);
        chk("video line trigger count", 32'(trig_cnt - base), 32'h0000_0001);
        // Status count, read-only status, then a reset in mid-run
        rd(`QTL_REG_STATUS, v);
        chk("status trigger count", {16'h0000, v[15:0]}, {16'h0000, trig_cnt[15:0]});
        wr(`QTL_REG_STATUS, 32'h0000_0000);
        rd(`QTL_REG_STATUS, v);
        chk("read-only status", {16'h0000, v[15:0]}, {16'h0000, trig_cnt[15:0]});
        rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        chk_resets();
        stop_test();
    end
endmodule // test_qualified_trigger_logic
`default_nettype wire
